// File: srt_pkg.sv
// Constants, register map and types for the sixteen-bit reload timer
package srt_pkg;

   // APB data and address widths, register width and prescaler width
   localparam int APB_DATA_W = 32;
   localparam int APB_ADDR_W = 20;
   localparam int REG_W      = 16;
   localparam int PRESC_W    = 14;

   // Printed register offsets, kept as word indices
   localparam logic [15:0] IDX_CH0_CLOCK_SELECT = 16'h4220;
   localparam logic [15:0] IDX_CH0_RELOAD_VALUE = 16'h4222;
   localparam logic [15:0] IDX_CH0_COUNT_VALUE  = 16'h4224;
   localparam logic [15:0] IDX_CH0_CONTROL      = 16'h4226;
   localparam logic [15:0] IDX_CH0_INT_STATUS   = 16'h4228;
   localparam logic [15:0] IDX_CH0_INT_MASK     = 16'h422A;
   localparam logic [15:0] IDX_CH1_CLOCK_SELECT = 16'h4240;

   // Byte addresses are four times the index
   localparam logic [APB_ADDR_W-1:0] ADDR_CH0_CLOCK_SELECT = 20'(IDX_CH0_CLOCK_SELECT) << 2;
   localparam logic [APB_ADDR_W-1:0] ADDR_CH0_RELOAD_VALUE = 20'(IDX_CH0_RELOAD_VALUE) << 2;
   localparam logic [APB_ADDR_W-1:0] ADDR_CH0_COUNT_VALUE  = 20'(IDX_CH0_COUNT_VALUE) << 2;
   localparam logic [APB_ADDR_W-1:0] ADDR_CH0_CONTROL      = 20'(IDX_CH0_CONTROL) << 2;
   localparam logic [APB_ADDR_W-1:0] ADDR_CH0_INT_STATUS   = 20'(IDX_CH0_INT_STATUS) << 2;
   localparam logic [APB_ADDR_W-1:0] ADDR_CH0_INT_MASK     = 20'(IDX_CH0_INT_MASK) << 2;
   localparam logic [APB_ADDR_W-1:0] ADDR_CH1_CLOCK_SELECT = 20'(IDX_CH1_CLOCK_SELECT) << 2;

   // Control register field positions, divider code width and interrupt status bit
   localparam int CTL_POLARITY_BIT = 10;
   localparam int CTL_MODE_LSB     = 8;
   localparam int CTL_ONESHOT_BIT  = 4;
   localparam int CTL_RESET_BIT    = 1;
   localparam int CTL_RUN_BIT      = 0;
   localparam int DIV_SEL_W        = 4;
   localparam int INT_UNDERFLOW_BIT = 0;

   // Reserved divider code
   localparam logic [DIV_SEL_W-1:0] DIV_RESERVED = 4'hF;

   // Reset values
   localparam logic [DIV_SEL_W-1:0] DIV_RST     = 4'h0;
   localparam logic [REG_W-1:0]     RELOAD_RST  = 16'h0000;
   localparam logic [REG_W-1:0]     COUNT_RST   = 16'hFFFF;
   localparam logic                 POLARITY_RST = 1'b1;
   localparam logic                 ONESHOT_RST = 1'b0;
   localparam logic                 RUN_RST     = 1'b0;
   localparam logic                 STATUS_RST  = 1'b0;
   localparam logic                 MASK_RST    = 1'b0;

   // Counting clock source and measurement mode
   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'h0,
      SRC_EXTERNAL = 2'h1,
      SRC_PULSE    = 2'h2,
      SRC_RESERVED = 2'h3
   } srt_src_t;

endpackage

// File: srt_prescaler.sv
// Free-running prescaler giving a one-cycle tick at ref_clk divided by 2^n
`timescale 1ns/1ps
module srt_prescaler (
   input  wire logic                            ref_clk,
   input  wire logic                            reset,
   input  wire logic [srt_pkg::DIV_SEL_W-1:0]   divider_select,
   output logic                                 tick
);
   import srt_pkg::*;

   typedef struct packed {
      logic [PRESC_W-1:0] cnt;
      logic               tick;
   } srt_presc_state_t;

   srt_presc_state_t state_q;
   srt_presc_state_t state_d;
   logic [PRESC_W-1:0] tap_mask;

   // Tick when the low n bits of the prescaler are all ones
   always_comb begin
      state_d     = state_q;
      state_d.cnt = state_q.cnt + 14'h0001;
      tap_mask    = PRESC_W'((15'h0001 << divider_select) - 15'h0001);
      if (divider_select == DIV_RESERVED) begin
         state_d.tick = 1'b0;
      end else begin
         state_d.tick = ((state_q.cnt & tap_mask) == tap_mask);
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign tick = state_q.tick;

endmodule

// File: srt_timer.sv
// Sixteen-bit reload timer channel with APB register access and interrupt
//
// Overview of operation
// - Four-bit divider code n picks ref_clk divided by 2^n; code 15 reserved.
// - Reload register is read/write over 0 to FFFF and resets to zero.
// - Counter value is read-only, full sixteen bits, resets to all ones.
// - Polarity bit picks high or low active external clock; resets high.
// - Two-bit source field: internal, external, pulse width; code 3 reserved.
// - One-shot bit: one stops after underflow, zero repeats; resets to repeat.
// - Run bit starts counting at one, stops at zero, readable, resets stopped.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module srt_timer #(
   parameter int ADDR_W = srt_pkg::APB_ADDR_W
) (
   input  wire logic                          ref_clk,
   input  wire logic                          reset,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [ADDR_W-1:0]             paddr,
   input  wire logic [srt_pkg::APB_DATA_W-1:0] pwdata,
   output logic      [srt_pkg::APB_DATA_W-1:0] prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          ext_clock_in,
   output logic                               underflow_pulse,
   output logic                               irq
);
   import srt_pkg::*;

   typedef struct packed {
      logic [DIV_SEL_W-1:0]  ch0_div;
      logic [DIV_SEL_W-1:0]  ch1_div;
      logic [REG_W-1:0]      reload;
      logic [REG_W-1:0]      count;
      logic                  polarity;
      srt_src_t              mode;
      logic                  oneshot;
      logic                  run;
      logic                  ext_s1;
      logic                  ext_s2;
      logic                  ext_prev;
      logic                  status;
      logic                  mask;
      logic                  pready;
      logic                  pslverr;
      logic [APB_DATA_W-1:0] prdata;
      logic                  uf_pulse;
      logic                  irq;
   } srt_state_t;

   srt_state_t state_q;
   srt_state_t state_d;

   logic                  tick;
   logic                  ext_active;
   logic                  ext_prev_active;
   logic                  ext_edge;
   logic                  count_clk;
   logic                  underflow;
   logic                  answer;
   logic                  commit_wr;
   logic                  hit_clk0;
   logic                  hit_reload;
   logic                  hit_count;
   logic                  hit_ctl;
   logic                  hit_stat;
   logic                  hit_mask;
   logic                  hit_clk1;
   logic                  hit_any;
   logic [APB_DATA_W-1:0] rd_word;
   logic [REG_W-1:0]      wr_half;

   // Prescaler for channel 0 counting clock
   srt_prescaler u_prescaler (
      .ref_clk        (ref_clk),
      .reset          (reset),
      .divider_select (state_q.ch0_div),
      .tick           (tick)
   );

   // Address decode; upper address bits must be zero to hit
   always_comb begin
      hit_clk0   = 1'b0;
      hit_reload = 1'b0;
      hit_count  = 1'b0;
      hit_ctl    = 1'b0;
      hit_stat   = 1'b0;
      hit_mask   = 1'b0;
      hit_clk1   = 1'b0;
      if (paddr == ADDR_W'(ADDR_CH0_CLOCK_SELECT)) begin
         hit_clk0 = 1'b1;
      end else if (paddr == ADDR_W'(ADDR_CH0_RELOAD_VALUE)) begin
         hit_reload = 1'b1;
      end else if (paddr == ADDR_W'(ADDR_CH0_COUNT_VALUE)) begin
         hit_count = 1'b1;
      end else if (paddr == ADDR_W'(ADDR_CH0_CONTROL)) begin
         hit_ctl = 1'b1;
      end else if (paddr == ADDR_W'(ADDR_CH0_INT_STATUS)) begin
         hit_stat = 1'b1;
      end else if (paddr == ADDR_W'(ADDR_CH0_INT_MASK)) begin
         hit_mask = 1'b1;
      end else if (paddr == ADDR_W'(ADDR_CH1_CLOCK_SELECT)) begin
         hit_clk1 = 1'b1;
      end
      hit_any = hit_clk0 | hit_reload | hit_count | hit_ctl | hit_stat | hit_mask | hit_clk1;
   end

   // Read mux; reserved and write-only bits read as zero
   always_comb begin
      rd_word = '0;
      if (hit_clk0) begin
         rd_word[DIV_SEL_W-1:0] = state_q.ch0_div;
      end else if (hit_reload) begin
         rd_word[REG_W-1:0] = state_q.reload;
      end else if (hit_count) begin
         rd_word[REG_W-1:0] = state_q.count;
      end else if (hit_ctl) begin
         rd_word[CTL_POLARITY_BIT]            = state_q.polarity;
         rd_word[CTL_MODE_LSB +: 2]           = state_q.mode;
         rd_word[CTL_ONESHOT_BIT]             = state_q.oneshot;
         rd_word[CTL_RUN_BIT]                 = state_q.run;
      end else if (hit_stat) begin
         rd_word[INT_UNDERFLOW_BIT] = state_q.status;
      end else if (hit_mask) begin
         rd_word[INT_UNDERFLOW_BIT] = state_q.mask;
      end else if (hit_clk1) begin
         rd_word[DIV_SEL_W-1:0] = state_q.ch1_div;
      end
   end

   // External clock: sync flops feed a level compare against the polarity
   assign ext_active      = (state_q.ext_s2 == state_q.polarity);
   assign ext_prev_active = (state_q.ext_prev == state_q.polarity);
   assign ext_edge        = ext_active & ~ext_prev_active;

   // Source select; pulse width gates the prescaled tick with the input level
   always_comb begin
      case (state_q.mode)
         SRC_INTERNAL: begin
            count_clk = tick;
         end
         SRC_EXTERNAL: begin
            count_clk = ext_edge;
         end
         SRC_PULSE: begin
            count_clk = tick & ext_active;
         end
         default: begin
            count_clk = 1'b0;
         end
      endcase
   end

   // One wait cycle before pready, so read data always come from a register
   assign answer    = psel & penable & ~state_q.pready;
   assign commit_wr = psel & penable & state_q.pready & pwrite & hit_any;
   assign underflow = state_q.run & count_clk & (state_q.count == '0);
   assign wr_half   = pwdata[REG_W-1:0];

   // Next state of the whole channel
   always_comb begin
      state_d          = state_q;
      state_d.ext_s1   = ext_clock_in;
      state_d.ext_s2   = state_q.ext_s1;
      state_d.ext_prev = state_q.ext_s2;
      state_d.pready   = answer;
      state_d.pslverr  = answer & ~hit_any;
      if (answer) begin
         state_d.prdata = pwrite ? '0 : rd_word;
      end

      // Count down; reload on underflow, one-shot drops the run bit
      if (state_q.run && count_clk) begin
         if (underflow) begin
            state_d.count = state_q.reload;
            if (state_q.oneshot) begin
               state_d.run = 1'b0;
            end
         end else begin
            state_d.count = state_q.count - 16'h0001;
         end
      end

      // Register writes land after counting so software wins the run bit
      if (commit_wr) begin
         if (hit_clk0) begin
            state_d.ch0_div = wr_half[DIV_SEL_W-1:0];
         end else if (hit_reload) begin
            state_d.reload = wr_half;
         end else if (hit_ctl) begin
            state_d.polarity = wr_half[CTL_POLARITY_BIT];
            state_d.mode     = srt_src_t'(wr_half[CTL_MODE_LSB +: 2]);
            state_d.oneshot  = wr_half[CTL_ONESHOT_BIT];
            state_d.run      = wr_half[CTL_RUN_BIT];
            if (wr_half[CTL_RESET_BIT]) begin
               state_d.count = state_q.reload;
            end
         end else if (hit_stat) begin
            if (wr_half[INT_UNDERFLOW_BIT]) begin
               state_d.status = 1'b0;
            end
         end else if (hit_mask) begin
            state_d.mask = wr_half[INT_UNDERFLOW_BIT];
         end else if (hit_clk1) begin
            state_d.ch1_div = wr_half[DIV_SEL_W-1:0];
         end
      end

      // Underflow set beats a same-cycle clear so no event is lost
      if (underflow) begin
         state_d.status = 1'b1;
      end
      state_d.uf_pulse = underflow;
      state_d.irq      = state_d.status & state_d.mask;
   end

   // State register with documented reset values
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q          <= '0;
         state_q.ch0_div  <= DIV_RST;
         state_q.ch1_div  <= DIV_RST;
         state_q.reload   <= RELOAD_RST;
         state_q.count    <= COUNT_RST;
         state_q.polarity <= POLARITY_RST;
         state_q.mode     <= SRC_INTERNAL;
         state_q.oneshot  <= ONESHOT_RST;
         state_q.run      <= RUN_RST;
         state_q.status   <= STATUS_RST;
         state_q.mask     <= MASK_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from the state register
   assign prdata          = state_q.prdata;
   assign pready          = state_q.pready;
   assign pslverr         = state_q.pslverr;
   assign underflow_pulse = state_q.uf_pulse;
   assign irq             = state_q.irq;

endmodule

// File: srt_timer_sva.sv
// Port-level assertions for the reload timer, bound onto srt_timer
`timescale 1ns/1ps
module srt_timer_sva #(
   parameter int ADDR_W = 20
) (
   input wire logic              ref_clk,
   input wire logic              reset,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              ext_clock_in,
   input wire logic              underflow_pulse,
   input wire logic              irq
);
   import srt_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic acc;
   logic mapped;
   // Access phase and address decode seen from the bus
   assign acc = psel && penable;
   assign mapped = paddr inside {ADDR_CH0_CLOCK_SELECT, ADDR_CH0_RELOAD_VALUE,
      ADDR_CH0_COUNT_VALUE, ADDR_CH0_CONTROL, ADDR_CH0_INT_STATUS, ADDR_CH0_INT_MASK,
      ADDR_CH1_CLOCK_SELECT};
   a_ready_wait: assert property (acc && !pready |=> pready) else $error("ready late");
   a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
   a_ready_cause: assert property (pready |-> $past(acc)) else $error("ready unasked");
   a_err_unmapped: assert property (acc && !pready && !mapped |=> pslverr) else $error("no err");
   a_err_mapped: assert property (acc && !pready && mapped |=> !pslverr) else $error("bad err");
   a_err_rdata: assert property (pslverr && !pwrite |-> prdata == '0) else $error("err data");
   // Reset clears prdata and irq, so the first edge after release is not a bus event
   a_rdata_held: assert property (!$stable(prdata) && !$past(reset) |-> pready)
      else $error("rdata moved");
   // A completed write takes effect at its ready edge and irq shows it at that same edge
   a_irq_rise: assert property ($rose(irq) |-> underflow_pulse || $past(underflow_pulse)
      || $past(acc && pready && pwrite)) else $error("irq rose without cause");
   a_irq_fall: assert property ($fell(irq) && !$past(reset) |-> $past(acc && pready && pwrite))
      else $error("irq fell without write");
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !pready && !irq
      && !underflow_pulse && prdata == '0) else $error("outputs not cleared");
   // Main scenarios reached
   c_underflow: cover property (underflow_pulse);
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule

bind srt_timer srt_timer_sva #(.ADDR_W(ADDR_W)) u_sva (.ref_clk(ref_clk), .reset(reset),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_in(ext_clock_in),
   .underflow_pulse(underflow_pulse), .irq(irq));

// File: tb_top.sv
// Self-checking testbench for the reload timer
`timescale 1ns/1ps
module tb_top;
   import srt_pkg::*;
   typedef struct {logic w; logic [19:0] a; logic [31:0] d; logic [31:0] x; logic e;} srt_row_t;
   logic        ref_clk, reset, psel, penable, pwrite, ext_clock_in;
   logic        pready, pslverr, underflow_pulse, irq, er;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_fail, compares, p;
   // Register rows: reset values first, then write and read-back pairs, with an unmapped read and write inside the last pair
   srt_row_t rows [17] = '{
      '{0, ADDR_CH0_CLOCK_SELECT, 32'h0, 32'h0, 0},
      '{0, ADDR_CH0_RELOAD_VALUE, 32'h0, 32'h0, 0},
      '{0, ADDR_CH0_COUNT_VALUE, 32'h0, 32'hFFFF, 0},
      '{0, ADDR_CH0_CONTROL, 32'h0, 32'h400, 0},
      '{0, ADDR_CH1_CLOCK_SELECT, 32'h0, 32'h0, 0},
      '{1, ADDR_CH0_CLOCK_SELECT, 32'hE, 32'h0, 0},
      '{0, ADDR_CH0_CLOCK_SELECT, 32'h0, 32'hE, 0},
      '{1, ADDR_CH0_RELOAD_VALUE, 32'hFFFF, 32'h0, 0},
      '{0, ADDR_CH0_RELOAD_VALUE, 32'h0, 32'hFFFF, 0},
      '{1, ADDR_CH0_COUNT_VALUE, 32'h1234, 32'h0, 0},
      '{0, ADDR_CH0_COUNT_VALUE, 32'h0, 32'hFFFF, 0},
      '{1, ADDR_CH0_CONTROL, 32'h712, 32'h0, 0},
      '{0, ADDR_CH0_CONTROL, 32'h0, 32'h710, 0},
      '{1, ADDR_CH1_CLOCK_SELECT, 32'hF, 32'h0, 0},
      '{0, 20'h10884, 32'h0, 32'h0, 1},
      '{1, 20'h10884, 32'h5, 32'h0, 1},
      '{0, ADDR_CH1_CLOCK_SELECT, 32'h0, 32'hF, 0}};

   srt_timer uut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_clock_in(ext_clock_in), .underflow_pulse(underflow_pulse),
      .irq(irq));

   // 200 MHz clock
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // One APB transfer; an idle edge follows so back-to-back calls never retouch psel
   task automatic apb(logic w, logic [19:0] a, logic [31:0] d);
      int k;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin n_fail++; close_out(); end
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
      @(posedge ref_clk);
   endtask

   task automatic rdc(logic [19:0] a, logic [31:0] x, string nm);
      apb(0, a, 32'h0);
      chk(nm, rd, x);
   endtask

   task automatic run_rows(int lo, int hi);
      for (int i = lo; i <= hi; i++) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk("slverr", {31'h0, er}, {31'h0, rows[i].e});
         if (!rows[i].w) chk("rdata", rd, rows[i].x);
      end
   endtask

   // Bounded wait for an underflow pulse, then cycles to the next one
   task automatic period(output int n);
      int k;
      k = 0;
      do begin @(posedge ref_clk); k++; end while (underflow_pulse !== 1'b1 && k < 200);
      if (k >= 200) begin n_fail++; close_out(); end
      n = 0;
      do begin @(posedge ref_clk); n++; end while (underflow_pulse !== 1'b1 && n < 200);
   endtask

   initial begin
      reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      ext_clock_in = 0; n_fail = 0; compares = 0;
      repeat (2) @(posedge ref_clk);
      reset <= 0;
      @(posedge ref_clk);
      run_rows(0, 16);
      // Internal clock, repeat mode, divide by 1 then by 4
      apb(1, ADDR_CH0_CLOCK_SELECT, 32'h0);
      apb(1, ADDR_CH0_RELOAD_VALUE, 32'h3);
      apb(1, ADDR_CH0_INT_MASK, 32'h1);
      apb(1, ADDR_CH0_CONTROL, 32'h402);
      rdc(ADDR_CH0_COUNT_VALUE, 32'h3, "strobe load");
      apb(1, ADDR_CH0_CONTROL, 32'h401);
      period(p);
      chk("period div1", p, 4);
      apb(1, ADDR_CH0_CLOCK_SELECT, 32'h2);
      period(p);
      chk("period div4", p, 16);
      rdc(ADDR_CH0_INT_STATUS, 32'h1, "status");
      chk("irq set", {31'h0, irq}, 32'h1);
      // One-shot stops itself after the underflow, holding the reloaded count
      apb(1, ADDR_CH0_CLOCK_SELECT, 32'h0);
      apb(1, ADDR_CH0_CONTROL, 32'h413);
      period(p);
      rdc(ADDR_CH0_CONTROL, 32'h410, "oneshot run");
      rdc(ADDR_CH0_COUNT_VALUE, 32'h3, "stopped count");
      // Write-one clear, then a masked underflow keeps irq low
      apb(1, ADDR_CH0_INT_STATUS, 32'h1);
      rdc(ADDR_CH0_INT_STATUS, 32'h0, "status clr");
      chk("irq clr", {31'h0, irq}, 32'h0);
      apb(1, ADDR_CH0_INT_MASK, 32'h0);
      apb(1, ADDR_CH0_CONTROL, 32'h413);
      repeat (12) @(posedge ref_clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1, ADDR_CH0_INT_MASK, 32'h1);
      @(posedge ref_clk);
      chk("irq unmasked", {31'h0, irq}, 32'h1);
      // External clock, high active: two rising edges
      apb(1, ADDR_CH0_CONTROL, 32'h502);
      apb(1, ADDR_CH0_CONTROL, 32'h501);
      repeat (2) begin
         ext_clock_in <= 1;
         repeat (4) @(posedge ref_clk);
         ext_clock_in <= 0;
         repeat (4) @(posedge ref_clk);
      end
      rdc(ADDR_CH0_COUNT_VALUE, 32'h1, "ext count");
      // External clock, low active: each falling edge counts once
      apb(1, ADDR_CH0_CONTROL, 32'h102);
      apb(1, ADDR_CH0_CONTROL, 32'h101);
      repeat (2) begin
         ext_clock_in <= 1;
         repeat (4) @(posedge ref_clk);
         ext_clock_in <= 0;
         repeat (4) @(posedge ref_clk);
      end
      rdc(ADDR_CH0_COUNT_VALUE, 32'h1, "ext low count");
      // Pulse width: ten cycles high at divide by 1
      apb(1, ADDR_CH0_RELOAD_VALUE, 32'h100);
      apb(1, ADDR_CH0_CONTROL, 32'h602);
      apb(1, ADDR_CH0_CONTROL, 32'h601);
      ext_clock_in <= 1;
      repeat (10) @(posedge ref_clk);
      ext_clock_in <= 0;
      repeat (6) @(posedge ref_clk);
      rdc(ADDR_CH0_COUNT_VALUE, 32'hF6, "pulse width");
      // Reserved source code: nothing counts
      apb(1, ADDR_CH0_CONTROL, 32'h701);
      ext_clock_in <= 1;
      repeat (8) @(posedge ref_clk);
      ext_clock_in <= 0;
      rdc(ADDR_CH0_COUNT_VALUE, 32'hF6, "reserved mode");
      // Reserved divider code: internal clock gives no ticks
      apb(1, ADDR_CH0_CLOCK_SELECT, 32'hF);
      apb(1, ADDR_CH0_CONTROL, 32'h401);
      repeat (8) @(posedge ref_clk);
      rdc(ADDR_CH0_COUNT_VALUE, 32'hF6, "reserved divider");
      // Reset in mid-run restores the register defaults
      apb(1, ADDR_CH0_CONTROL, 32'h401);
      repeat (5) @(posedge ref_clk);
      reset <= 1;
      repeat (2) @(posedge ref_clk);
      reset <= 0;
      @(posedge ref_clk);
      run_rows(0, 4);
      close_out();
   end
endmodule
